// *** nipc_ctrl.sv ***
// nipc_ctrl: nested interrupt priority controller top
//
// How it works
// - priority codes 10,01,00,11 mean levels 0..3
// - entry loads cc bits 5,3 from vector
// - trap and reset preempt level 3
// - cc resets to 111x 1010, level 3
// - vector priority registers reset to ff
// - vector x pair in register x/4
// - written level 0 pair keeps old value
// - trap sets both cc priority bits
// - raised priority of running vector re-enters
// - enable loads 10, disable loads 11
// - halt, wait, pop, enable, disable change level
// - branch flags for level 3 and not
// - edge, both, low and high level sensing
// - two group sensitivity selections, each shared by a pair of groups
// - sensitivity writes only at level 3
// - changed sensitivity clears affected pending requests
// - upper field second port, lower first port
// - single groups decode 00..11 plainly
// - polarity bit inverts its group
// - serve only enabled requests above current level
//
// The implementer's own choices: the address map and the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
module nipc_ctrl (
  // clock and reset
  input  wire logic                  CLK,
  input  wire logic                  RST,
  // register port
  input  wire logic [2:0]            ADDR,
  input  wire logic [7:0]            WDATA,
  input  wire logic                  WR,
  input  wire logic                  RD,
  output logic      [7:0]            RDATA,
  // cpu core
  input  wire nipc_pkg::nipc_cpu_ev_t CPU_EV,
  input  wire logic [7:0]            CONDITION_CODE_IN,
  output logic      [7:0]            CC_OUT,
  output logic                       BR_MASKED,
  output logic                       BR_UNMASKED,
  // request to the core
  output logic                       IRQ_REQ,
  output logic      [3:0]            IRQ_VEC,
  // interrupt sources
  input  wire logic [3:0]            PIN_A,
  input  wire logic [2:0]            PIN_F,
  input  wire logic [4:0]            PIN_B,
  input  wire logic [13:4]           PERIPH_REQ
);

  // ************************************************************
  // declarations
  // ************************************************************
  logic [7:0]  cc_reg;
  logic [7:0]  cc_next;
  logic [7:0]  prio_reg [4];
  logic [7:0]  ext_reg;
  logic [7:0]  rdata_reg;
  logic        masked_reg;
  logic        unmasked_reg;
  logic        irq_req_reg;
  logic [3:0]  irq_vec_reg;
  logic [31:0] prio_flat;
  logic [13:0] req;
  logic [3:0]  grp_req;
  logic [3:0]  grp_clr_cfg;
  logic [3:0]  grp_clr_ack;
  logic [15:0] grp_pins;
  logic [7:0]  grp_sense;
  logic [3:0]  grp_inv;
  logic        cur_lvl3;
  logic [1:0]  cur_lvl;
  logic        ack_take;
  logic        ext_wr_ok;
  logic [7:0]  ext_new;
  logic        best_found;
  logic [1:0]  best_lvl;
  logic [3:0]  best_vec;
  logic [1:0]  vec_lvl;
  logic [1:0]  cpu_code;
  logic        cpu_code_ld;

  assign cur_lvl3 = cc_reg[nipc_pkg::CC_HI_POS] & cc_reg[nipc_pkg::CC_LO_POS];
  assign cur_lvl  = nipc_pkg::lvl({cc_reg[nipc_pkg::CC_HI_POS],
                                   cc_reg[nipc_pkg::CC_LO_POS]});
  assign ack_take = CPU_EV.irq_ack & irq_req_reg;

  // flat view of the four priority registers
  assign prio_flat = {prio_reg[3], prio_reg[2], prio_reg[1], prio_reg[0]};

  // ************************************************************
  // condition code priority bits
  // ************************************************************

  // fixed-code instructions, disable highest
  always_comb begin
    cpu_code_ld = 1'b1;
    if (CPU_EV.disable_irq_instr) begin
      cpu_code = nipc_pkg::NIPC_LVL3;
    end else if (CPU_EV.enable_irq_instr || CPU_EV.halt
                 || CPU_EV.wait_irq_instr) begin
      cpu_code = nipc_pkg::NIPC_LVL0;
    end else begin
      cpu_code    = nipc_pkg::NIPC_LVL3;
      cpu_code_ld = 1'b0;
    end
  end

  // next cc: trap, entry, pop/return, instruction, bus write
  always_comb begin
    cc_next = cc_reg;
    if (CPU_EV.trap) begin
      cc_next[nipc_pkg::CC_HI_POS] = 1'b1;
      cc_next[nipc_pkg::CC_LO_POS] = 1'b1;
    end else if (ack_take) begin
      cc_next[nipc_pkg::CC_HI_POS] = prio_flat[2*irq_vec_reg+1];
      cc_next[nipc_pkg::CC_LO_POS] = prio_flat[2*irq_vec_reg];
    end else if (CPU_EV.irq_return_instr || CPU_EV.pop_cc) begin
      cc_next = CONDITION_CODE_IN;
    end else if (cpu_code_ld) begin
      cc_next[nipc_pkg::CC_HI_POS] = cpu_code[1];
      cc_next[nipc_pkg::CC_LO_POS] = cpu_code[0];
    end else if (WR && ADDR == nipc_pkg::ADDR_CC) begin
      cc_next = WDATA;
    end
  end

  // cc register, level 3 out of reset
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      cc_reg <= nipc_pkg::CC_RESET;
    end else begin
      cc_reg <= cc_next;
    end
  end

  // branch condition flags follow the cc bits
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      masked_reg   <= 1'b1;
      unmasked_reg <= 1'b0;
    end else begin
      masked_reg   <= cc_next[nipc_pkg::CC_HI_POS]
                      & cc_next[nipc_pkg::CC_LO_POS];
      unmasked_reg <= ~(cc_next[nipc_pkg::CC_HI_POS]
                      & cc_next[nipc_pkg::CC_LO_POS]);
    end
  end

  // ************************************************************
  // vector priority registers
  // ************************************************************

  // one pair per vector; a level 0 pattern is refused per pair
  for (genvar p = 0; p < nipc_pkg::NUM_PAIR; p++) begin : g_pair
    always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
        prio_reg[p/4][2*(p%4)+:2] <= nipc_pkg::PRIO_RESET[2*(p%4)+:2];
      end else if (WR && ADDR == nipc_pkg::ADDR_PRIO0 + 3'(p/4)
                   && WDATA[2*(p%4)+:2] != nipc_pkg::NIPC_LVL0) begin
        prio_reg[p/4][2*(p%4)+:2] <= WDATA[2*(p%4)+:2];
      end
    end
  end

  // ************************************************************
  // external sensitivity control
  // ************************************************************

  // writes accepted at level 3 only; reserved bits stay zero
  assign ext_wr_ok = WR && ADDR == nipc_pkg::ADDR_EXT_SENSE && cur_lvl3;
  assign ext_new   = WDATA & nipc_pkg::EXT_WMASK;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ext_reg <= nipc_pkg::EXT_RESET;
    end else if (ext_wr_ok) begin
      ext_reg <= ext_new;
    end
  end

  // pending clears for groups whose setting really changed
  always_comb begin
    grp_clr_cfg = 4'h0;
    if (ext_wr_ok) begin
      grp_clr_cfg[0] = ext_new[4:3] != ext_reg[4:3]
                       || ext_new[2] != ext_reg[2];
      grp_clr_cfg[1] = ext_new[4:3] != ext_reg[4:3];
      grp_clr_cfg[2] = ext_new[7:6] != ext_reg[7:6]
                       || ext_new[5] != ext_reg[5];
      grp_clr_cfg[3] = ext_new[7:6] != ext_reg[7:6];
    end
  end

  // group wiring: upper field second port, lower field first port
  assign grp_pins  = {3'h7, PIN_B[4], PIN_B[3:0], 1'b1, PIN_F, PIN_A};
  assign grp_sense = {ext_reg[nipc_pkg::SENSE_UP_POS+:2],
                      ext_reg[nipc_pkg::SENSE_UP_POS+:2],
                      ext_reg[nipc_pkg::SENSE_LO_POS+:2],
                      ext_reg[nipc_pkg::SENSE_LO_POS+:2]};
  assign grp_inv   = {1'b0, ext_reg[nipc_pkg::POL_2ND_POS],
                      1'b0, ext_reg[nipc_pkg::POL_1ST_POS]};

  // entering a group's vector clears its edge latch
  assign grp_clr_ack = ack_take ? 4'(1 << irq_vec_reg) : 4'h0;

  for (genvar g = 0; g < nipc_pkg::NUM_GRP; g++) begin : g_grp
    nipc_ext_group u_grp (
      .clk     (CLK),
      .rst     (RST),
      .pins    (grp_pins[4*g+:4]),
      .sense   (grp_sense[2*g+:2]),
      .invert  (grp_inv[g]),
      .clr_cfg (grp_clr_cfg[g]),
      .clr_ack (grp_clr_ack[g]),
      .req     (grp_req[g])
    );
  end

  // peripheral requests come already gated by their enables
  assign req = {PERIPH_REQ, grp_req};

  // ************************************************************
  // arbitration
  // ************************************************************

  // highest level above current; strict compare keeps lower index
  always_comb begin
    best_found = 1'b0;
    best_lvl   = 2'd0;
    best_vec   = 4'h0;
    vec_lvl    = 2'd0;
    for (int v = 0; v < nipc_pkg::NUM_VEC; v++) begin
      vec_lvl = nipc_pkg::lvl(prio_flat[2*v+:2]);
      if (req[v] && vec_lvl > cur_lvl
          && (!best_found || vec_lvl > best_lvl)) begin
        best_found = 1'b1;
        best_lvl   = vec_lvl;
        best_vec   = 4'(v);
      end
    end
  end

  // registered request; dropped in the entry cycle
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      irq_req_reg <= 1'b0;
      irq_vec_reg <= 4'h0;
    end else begin
      irq_req_reg <= best_found & ~ack_take & ~CPU_EV.trap;
      irq_vec_reg <= best_vec;
    end
  end

  // ************************************************************
  // register read port
  // ************************************************************

  // read data one cycle after the strobe, zero elsewhere
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      rdata_reg <= 8'h00;
    end else if (RD) begin
      if (ADDR == nipc_pkg::ADDR_CC) begin
        rdata_reg <= cc_reg;
      end else if (ADDR >= nipc_pkg::ADDR_PRIO0
                   && ADDR <= nipc_pkg::ADDR_PRIO3) begin
        rdata_reg <= prio_reg[2'(ADDR - nipc_pkg::ADDR_PRIO0)];
      end else if (ADDR == nipc_pkg::ADDR_EXT_SENSE) begin
        rdata_reg <= ext_reg;
      end else begin
        rdata_reg <= 8'h00;                            // unmapped
      end
    end else begin
      rdata_reg <= 8'h00;
    end
  end

  // outputs straight from flops
  assign RDATA       = rdata_reg;
  assign CC_OUT      = cc_reg;
  assign BR_MASKED   = masked_reg;
  assign BR_UNMASKED = unmasked_reg;
  assign IRQ_REQ     = irq_req_reg;
  assign IRQ_VEC     = irq_vec_reg;

  // ************************************************************
  // assertions
  // ************************************************************

  property p_branch_flags;
    @(posedge CLK) disable iff (RST)
    BR_MASKED == (CC_OUT[5] & CC_OUT[3]) && BR_UNMASKED == !BR_MASKED;
  endproperty
  a_branch_flags: assert property (p_branch_flags)
    else $error("branch flags disagree with cc");

  property p_entry_load;
    @(posedge CLK) disable iff (RST)
    ack_take && !CPU_EV.trap |=> {CC_OUT[5], CC_OUT[3]}
      == 2'($past(prio_flat) >> (2 * $past(IRQ_VEC)));
  endproperty
  a_entry_load: assert property (p_entry_load)
    else $error("entry did not load vector priority");

  property p_trap_lvl3;
    @(posedge CLK) disable iff (RST)
    CPU_EV.trap |=> CC_OUT[5] && CC_OUT[3] && BR_MASKED;
  endproperty
  a_trap_lvl3: assert property (p_trap_lvl3)
    else $error("trap did not set level 3");

  property p_enable_lvl0;
    @(posedge CLK) disable iff (RST)
    CPU_EV.enable_irq_instr && !CPU_EV.trap && !ack_take
      && !CPU_EV.pop_cc && !CPU_EV.irq_return_instr
      && !CPU_EV.disable_irq_instr |=> {CC_OUT[5], CC_OUT[3]} == 2'b10;
  endproperty
  a_enable_lvl0: assert property (p_enable_lvl0)
    else $error("enable did not load level 0");

  property p_halt_lvl0;
    @(posedge CLK) disable iff (RST)
    (CPU_EV.halt || CPU_EV.wait_irq_instr) && CPU_EV == (CPU_EV & 8'h30)
      |=> BR_UNMASKED && {CC_OUT[5], CC_OUT[3]} == 2'b10;
  endproperty
  a_halt_lvl0: assert property (p_halt_lvl0)
    else $error("halt or wait did not set level 0");

  property p_return_pop;
    @(posedge CLK) disable iff (RST)
    CPU_EV.irq_return_instr && !CPU_EV.trap && !ack_take
      |=> CC_OUT == $past(CONDITION_CODE_IN);
  endproperty
  a_return_pop: assert property (p_return_pop)
    else $error("return did not restore cc");

  property p_lvl0_refused;
    @(posedge CLK) disable iff (RST)
    WR && ADDR == nipc_pkg::ADDR_PRIO0 && WDATA[1:0] == 2'b10
      |=> $stable(prio_reg[0][1:0]);
  endproperty
  a_lvl0_refused: assert property (p_lvl0_refused)
    else $error("level 0 pair was stored");

  property p_sense_locked;
    @(posedge CLK) disable iff (RST)
    WR && ADDR == nipc_pkg::ADDR_EXT_SENSE && !cur_lvl3 |=> $stable(ext_reg);
  endproperty
  a_sense_locked: assert property (p_sense_locked)
    else $error("sensitivity changed below level 3");

  property p_req_above;
    @(posedge CLK) disable iff (RST)
    IRQ_REQ |-> 1'($past(req) >> IRQ_VEC) && nipc_pkg::lvl(
      2'($past(prio_flat) >> (2 * IRQ_VEC))) > $past(cur_lvl);
  endproperty
  a_req_above: assert property (p_req_above)
    else $error("request raised without higher priority");

endmodule : nipc_ctrl
`default_nettype wire

// *** nipc_pkg.sv ***
// nipc_pkg: shared constants and types of the nested interrupt priority block
package nipc_pkg;

  // ************************************************************
  // register port map
  // ************************************************************
  localparam int          ADDR_W        = 3;
  localparam logic [2:0]  ADDR_CC       = 3'h0;
  localparam logic [2:0]  ADDR_PRIO0    = 3'h1;
  localparam logic [2:0]  ADDR_PRIO3    = 3'h4;
  localparam logic [2:0]  ADDR_EXT_SENSE = 3'h5;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [7:0]  CC_RESET      = 8'hea;
  localparam logic [7:0]  PRIO_RESET    = 8'hff;
  localparam logic [7:0]  EXT_RESET     = 8'h00;
  localparam logic [7:0]  EXT_WMASK     = 8'hfc;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int          CC_HI_POS     = 5;
  localparam int          CC_LO_POS     = 3;
  localparam int          SENSE_UP_POS  = 6;
  localparam int          POL_2ND_POS   = 5;
  localparam int          SENSE_LO_POS  = 3;
  localparam int          POL_1ST_POS   = 2;

  // ************************************************************
  // sizes
  // ************************************************************
  localparam int          NUM_VEC       = 14;
  localparam int          NUM_PAIR      = 16;
  localparam int          NUM_GRP       = 4;
  localparam int          GRP_PINS      = 4;

  // priority codes as held in the priority bit pairs
  typedef enum logic [1:0] {
    NIPC_LVL0 = 2'b10,
    NIPC_LVL1 = 2'b01,
    NIPC_LVL2 = 2'b00,
    NIPC_LVL3 = 2'b11
  } nipc_code_t;

  // one-cycle strobes from the cpu core
  typedef struct packed {
    logic enable_irq_instr;
    logic disable_irq_instr;
    logic halt;
    logic wait_irq_instr;
    logic trap;
    logic irq_return_instr;
    logic pop_cc;
    logic irq_ack;
  } nipc_cpu_ev_t;

  // code to ordinal level, 0 lowest 3 highest
  function automatic logic [1:0] lvl(input logic [1:0] code);
    case (code)
      NIPC_LVL0: lvl = 2'd0;
      NIPC_LVL1: lvl = 2'd1;
      NIPC_LVL2: lvl = 2'd2;
      default:   lvl = 2'd3;
    endcase
  endfunction : lvl

endpackage : nipc_pkg

// *** nipc_ext_group.sv ***
// nipc_ext_group: one external pin group, sensitivity and request latch
`timescale 1ns/1ns
`default_nettype none
module nipc_ext_group (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // pins and setting
  input  wire logic [3:0] pins,
  input  wire logic [1:0] sense,
  input  wire logic       invert,
  // clears
  input  wire logic       clr_cfg,
  input  wire logic       clr_ack,
  // request
  output logic            req
);

  logic [3:0] sync1_reg;
  logic [3:0] sync2_reg;
  logic [3:0] prev_reg;
  logic       latch_reg;
  logic [3:0] cur;
  logic [3:0] old;
  logic       rise;
  logic       fall;
  logic       low;
  logic       ev;

  // two-stage pin synchroniser and history
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1_reg <= 4'hf;
      sync2_reg <= 4'hf;
      prev_reg  <= 4'hf;
    end else begin
      sync1_reg <= pins;
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
    end
  end

  // polarity swaps rising and falling, low and high
  assign cur  = sync2_reg ^ {4{invert}};
  assign old  = prev_reg ^ {4{invert}};
  assign rise = |(cur & ~old);
  assign fall = |(~cur & old);
  assign low  = |(~cur);                               // pins ored

  // sense decode: 00 fall+low, 01 rise, 10 fall, 11 both
  always_comb begin
    case (sense)
      2'b00:   ev = fall;
      2'b01:   ev = rise;
      2'b10:   ev = fall;
      default: ev = rise | fall;
    endcase
  end

  // edge latch, a new edge wins over any clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      latch_reg <= 1'b0;
    end else if (ev) begin
      latch_reg <= 1'b1;
    end else if (clr_cfg || clr_ack) begin
      latch_reg <= 1'b0;
    end
  end

  assign req = latch_reg | ((sense == 2'b00) & low);

endmodule : nipc_ext_group
`default_nettype wire

// *** nipc_core_model.sv ***
// nipc_core_model: cpu core stand-in that acks, stacks and pops cc
`timescale 1ns/1ns
`default_nettype none
module nipc_core_model (
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst,
  // from the block
  input  wire logic                   irq_req,
  input  wire logic [7:0]             cc_out,
  // bench commands
  input  wire logic                   auto_ack,
  input  wire logic [3:0]             ack_delay,
  input  wire nipc_pkg::nipc_cpu_ev_t cmd_ev,
  input  wire logic [7:0]             cmd_cc,
  // to the block
  output var  nipc_pkg::nipc_cpu_ev_t cpu_ev,
  output var  logic [7:0]             condition_code
);
  logic [7:0] stack_q [$];
  logic [3:0] wait_cnt;
  logic       ack_now;

  // ack once per request after the wait, never twice in a row
  assign ack_now = auto_ack && irq_req && !cpu_ev.irq_ack
                   && wait_cnt >= ack_delay;

  // ************************************************************
  // event replay, ack with delay, cc stack
  // ************************************************************
  // popped cc valid only beside its event, otherwise it toggles
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cpu_ev   <= '0;
      condition_code   <= 8'h00;
      wait_cnt <= 4'h0;
      stack_q.delete();
    end else begin
      cpu_ev <= nipc_pkg::nipc_cpu_ev_t'(cmd_ev | {7'h0, ack_now});
      if (cmd_ev.irq_return_instr && stack_q.size() > 0) begin
        condition_code <= stack_q.pop_back();
      end else if (cmd_ev.pop_cc) begin
        condition_code <= cmd_cc;
      end else begin
        condition_code <= ~condition_code;
      end
      // stack the cc of the level left
      if (ack_now) begin
        stack_q.push_back(cc_out);
      end
      if (auto_ack && irq_req && !cpu_ev.irq_ack && !ack_now) begin
        wait_cnt <= wait_cnt + 4'h1;
      end else begin
        wait_cnt <= 4'h0;
      end
    end
  end
endmodule : nipc_core_model
`default_nettype wire

// *** nipc_ctrl_tb_top.sv ***
// nipc_ctrl_tb_top: self-checking bench of the priority controller
`timescale 1ns/1ns
`default_nettype none
module nipc_ctrl_tb_top;
  logic                   clk, rst, wr_s, rd_s, auto_ack;
  logic [2:0]             addr;
  logic [7:0]             wdata, rdata, cc_out, pop_val, condition_code;
  logic                   br_m, br_u, irq_req;
  logic [3:0]             irq_vec, pin_a, ack_delay;
  logic [2:0]             pin_f;
  logic [4:0]             pin_b;
  logic [13:4]            periph;
  nipc_pkg::nipc_cpu_ev_t cpu_ev, cmd_ev;
  int                     n_fail, compares;

  nipc_ctrl dut (
    .CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr_s),
    .RD(rd_s), .RDATA(rdata), .CPU_EV(cpu_ev), .CONDITION_CODE_IN(condition_code),
    .CC_OUT(cc_out), .BR_MASKED(br_m), .BR_UNMASKED(br_u),
    .IRQ_REQ(irq_req), .IRQ_VEC(irq_vec), .PIN_A(pin_a), .PIN_F(pin_f),
    .PIN_B(pin_b), .PERIPH_REQ(periph));

  nipc_core_model core (
    .clk(clk), .rst(rst), .irq_req(irq_req), .cc_out(cc_out),
    .auto_ack(auto_ack), .ack_delay(ack_delay), .cmd_ev(cmd_ev),
    .cmd_cc(pop_val), .cpu_ev(cpu_ev), .condition_code(condition_code));

  // clock, 4 ns period
  always #2 clk = ~clk;

  // ************************************************************
  // helpers
  // ************************************************************
  task automatic give_verdict;
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // priority code and branch flags together
  task automatic check_code(input logic [1:0] c);
    chk({6'h0, cc_out[5], cc_out[3]}, {6'h0, c});
    chk({6'h0, br_m, br_u}, (c == 2'b11) ? 8'h02 : 8'h01);
  endtask : check_code

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr_s  <= 1'b1;
    @(posedge clk);
    wr_s  <= 1'b0;
    #1;
  endtask : wr

  // data stands only in the cycle after the strobe
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    chk(rdata, e);
  endtask : rd

  task automatic do_ev(input logic [7:0] v);
    @(posedge clk);
    cmd_ev <= nipc_pkg::nipc_cpu_ev_t'(v);
    @(posedge clk);
    cmd_ev <= '0;
    repeat (2) @(posedge clk);
    #1;
  endtask : do_ev

  // bounded wait for a request level, timeout ends the run
  task automatic wait_req(input logic lvl);
    for (int k = 0; k < 12; k++) begin
      @(posedge clk);
      #1;
      if (irq_req === lvl) return;
    end
    n_fail++;
    $display("unexpected at %0t: got %h exp %h", $time, irq_req, lvl);
    give_verdict();
  endtask : wait_req

  task automatic wait_irq(input logic [3:0] v);
    wait_req(1'b1);
    chk({4'h0, irq_vec}, {4'h0, v});
  endtask : wait_irq

  task automatic no_irq(input int n);
    repeat (n) begin
      @(posedge clk);
      #1;
      chk({7'h0, irq_req}, 8'h00);
    end
  endtask : no_irq

  // let the core ack after d cycles, wait until taken
  task automatic take_irq(input logic [3:0] d);
    @(posedge clk);
    ack_delay <= d;
    auto_ack  <= 1'b1;
    wait_req(1'b0);
    @(posedge clk);
    auto_ack  <= 1'b0;
    #1;
  endtask : take_irq

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_reset;
    chk(cc_out, nipc_pkg::CC_RESET);
    check_code(2'b11);
    for (int i = 1; i < 5; i++) rd(3'(i), nipc_pkg::PRIO_RESET);
    rd(nipc_pkg::ADDR_EXT_SENSE, 8'h00);
    wr(3'h6, 8'h5a);
    rd(3'h6, 8'h00);
    wr(3'h1, 8'hcf);
    rd(3'h1, 8'hcf);
    wr(3'h1, 8'h64);
    rd(3'h1, 8'h44);
  endtask : t_reset

  task automatic t_instr;
    logic [7:0] evs [3] = '{8'h80, 8'h20, 8'h10};
    for (int i = 0; i < 3; i++) begin
      do_ev(8'h40);
      check_code(2'b11);
      do_ev(evs[i]);
      check_code(2'b10);
    end
    @(posedge clk) pop_val <= 8'hc8;
    do_ev(8'h02);
    check_code(2'b01);
    wr(3'h0, 8'hc0);
    check_code(2'b00);
    do_ev(8'h08);
    check_code(2'b11);
    do_ev(8'h08);
    check_code(2'b11);
  endtask : t_instr

  task automatic t_service;
    do_ev(8'h80);
    wr(3'h2, 8'hf5);
    @(posedge clk) periph <= 10'h003;
    wait_irq(4'h4);
    take_irq(4'h0);
    check_code(2'b01);
    no_irq(6);
    wr(3'h2, 8'hf4);
    wait_irq(4'h4);
    take_irq(4'h3);
    check_code(2'b00);
    @(posedge clk) periph <= 10'h004;
    do_ev(8'h04);
    check_code(2'b01);
    do_ev(8'h04);
    check_code(2'b10);
    wait_irq(4'h6);
    do_ev(8'h40);
    no_irq(8);
    @(posedge clk) periph <= 10'h000;
  endtask : t_service

  task automatic t_sense;
    do_ev(8'h40);
    wr(3'h5, 8'h0c);
    rd(3'h5, 8'h0c);
    @(posedge clk) pin_a <= 4'he;
    repeat (6) @(posedge clk);
    wr(3'h5, 8'h14);
    do_ev(8'h80);
    no_irq(8);
    @(posedge clk) pin_a <= 4'hf;
    wait_irq(4'h0);
    wr(3'h5, 8'h00);
    rd(3'h5, 8'h14);
    do_ev(8'h40);
  endtask : t_sense

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    {wr_s, rd_s, auto_ack} = 3'h0;
    {addr, wdata, pop_val, ack_delay} = '0;
    {pin_a, pin_f, pin_b} = 12'hfff;
    periph   = '0;
    cmd_ev   = '0;
    n_fail   = 0;
    compares = 0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    #1;
    t_reset();
    t_instr();
    t_service();
    t_sense();
    give_verdict();
  end
endmodule : nipc_ctrl_tb_top
`default_nettype wire
